/* File: inc/pin_func_map.vh */
// Register offsets, field positions and reset values for the pin function block
`ifndef PIN_FUNC_MAP_VH
`define PIN_FUNC_MAP_VH

`define ADDR_W              8
`define OFS_PORT_F_FUNC     8'h44
`define OFS_ALT_FUNC        8'h50
`define PF_SEL_PS2_RST      2'b11
`define PF_SEL_HI_LSB       2
`define PF_SEL_HI_MSB       3
`define PF_SCHMITT_RST      4'h0
`define PF_SCHMITT_LSB      16
`define PF_SCHMITT_MSB      19
`define CFG_XTAL_BIT        27
`define ALT_PB15_BIT        24
`define ALT_PB2_TMR_BIT     26
`define ALT_PB8_CLK_BIT     29
`define ALT_PB2_CMP_BIT     30
`define ALT_RW_MASK         32'h6400_0000
`define ALT_PB15_MASK       32'h0100_0000
`define ALT_RESET           32'h0000_0000
`define PB_SEL_W            16

// Pin function codes
`define FN_GPIO             3'h0
`define FN_PB2_RTS          3'h1
`define FN_PB2_TMR2_EXT     3'h2
`define FN_PB2_CMP0         3'h3
`define FN_PB8_TMR0_OUT     3'h1
`define FN_PB8_CLK_OUT      3'h2
`define FN_PB15_EXT_EXTERNAL_INTERRUPT_1    3'h1
`define FN_PB15_TMR0_EXT    3'h2

`endif

/* File: hdl/pin_decode_two.v */
// Two-bit function decode for one port B pin
`timescale 1ns/1ps
`default_nettype none

module pin_decode_two #(
    parameter [2:0] FN_PORT_ONLY = 3'h1,   // Code for pattern 01
    parameter [2:0] FN_BOTH      = 3'h2    // Code for pattern 11
) (
    input  wire       i_alt_sel,   // Alternative select bit
    input  wire       i_port_sel,  // Port B select bit
    output reg  [2:0] o_func       // Function code
);

    // Unlisted patterns 00 and 10 fall back to GPIO
    always @* begin
        case ({i_alt_sel, i_port_sel})
            2'b01:   o_func = FN_PORT_ONLY;
            2'b11:   o_func = FN_BOTH;
            default: o_func = 3'h0;
        endcase
    end

endmodule
`default_nettype wire

/* File: hdl/pin_decode_pb2.v */
// Three-bit function decode for pin PB.2
`timescale 1ns/1ps
`default_nettype none
`include "pin_func_map.vh"

module pin_decode_pb2 (
    input  wire       i_cmp_sel,   // Comparator output select
    input  wire       i_tmr_sel,   // Timer 2 external select
    input  wire       i_port_sel,  // Port B select bit 2
    output reg  [2:0] o_func       // Function code
);

    // Listed patterns only; others fall back to GPIO
    always @* begin
        case ({i_cmp_sel, i_tmr_sel, i_port_sel})
            3'b001:  o_func = `FN_PB2_RTS;
            3'b011:  o_func = `FN_PB2_TMR2_EXT;
            3'b101:  o_func = `FN_PB2_CMP0;
            default: o_func = `FN_GPIO;
        endcase
    end

endmodule
`default_nettype wire

/* File: hdl/pin_func_select.v */
// Port F pin mux, Schmitt enables and alternative pin function register
`timescale 1ns/1ps
`default_nettype none
`include "pin_func_map.vh"

// Function
// - PF.3 and PF.2 select bits reset to 1 (PS/2 lines).
// - PF.1 and PF.0 selects read-only, copied from configuration word bit 27.
// - Bits 19..16 enable Schmitt input of PF.3..PF.0 when set.
// - PF.3 select: 0 GPIO, 1 PS/2 clock line.
// - PF.2 select: 0 GPIO, 1 PS/2 data line.
// - PF.1 select: 0 GPIO, 1 crystal oscillator input.
// - PF.0 select: 0 GPIO, 1 crystal oscillator output.
// - Alternative register read-write, resets to zero.
// - PB.2 decoded from alt bits 30, 26 and port B bit 2.
// - PB.8 decoded from alt bit 29 and port B bit 8.
// - PB.15 decoded from alt bit 24 and port B bit 15.
module pin_func_select (
    input  wire                 i_clk_sys,        // System clock, 200 MHz
    input  wire                 i_rst,            // Synchronous reset, active high
    input  wire [`ADDR_W-1:0]   i_addr,           // Register byte address
    input  wire [31:0]          i_wdata,          // Write data
    input  wire                 i_wr,             // Write strobe
    input  wire                 i_rd,             // Read strobe
    output reg  [31:0]          o_rdata,          // Read data, cycle after strobe
    input  wire [31:0]          i_config_word,    // First configuration word
    input  wire [`PB_SEL_W-1:0] i_port_b_sel,     // Port B select bits
    output reg                  o_pf3_ps2_port_clock_line,    // PF.3 on PS/2 clock line
    output reg                  o_pf2_ps2_port_data_line,    // PF.2 on PS/2 data line
    output reg                  o_pf1_xtal_in,    // PF.1 on crystal input
    output reg                  o_pf0_xtal_out,   // PF.0 on crystal output
    output reg  [3:0]           o_pf_schmitt_en,  // PF.3..PF.0 Schmitt enables
    output reg  [2:0]           o_pb2_func,       // PB.2 function code
    output reg  [2:0]           o_pb8_func,       // PB.8 function code
    output reg  [2:0]           o_pb15_func       // PB.15 function code
);

    reg  [1:0]  pf_sel_hi_q;      // PF.3, PF.2 selects
    reg  [1:0]  pf_sel_hi_d;
    reg  [3:0]  schmitt_q;        // Schmitt enable field
    reg  [3:0]  schmitt_d;
    reg  [31:0] alt_q;            // Alternative register, implemented bits only
    reg  [31:0] alt_d;
    wire        xtal_cfg;         // Configuration bit for PF.1/PF.0
    wire [31:0] port_f_rd;
    wire [2:0]  pb2_fn;
    wire [2:0]  pb8_fn;
    wire [2:0]  pb15_fn;
    wire        wr_port_f;
    wire        wr_alt;

    assign xtal_cfg  = i_config_word[`CFG_XTAL_BIT];
    assign wr_port_f = i_wr && (i_addr == `OFS_PORT_F_FUNC);
    assign wr_alt    = i_wr && (i_addr == `OFS_ALT_FUNC);

    // Port F read image; reserved bits zero, low selects from config
    assign port_f_rd = {12'h000, schmitt_q, 12'h000,
                        pf_sel_hi_q, xtal_cfg, xtal_cfg};

    // Next state of writable fields
    always @* begin
        pf_sel_hi_d = pf_sel_hi_q;
        schmitt_d   = schmitt_q;
        alt_d       = alt_q;
        if (wr_port_f) begin
            pf_sel_hi_d = i_wdata[`PF_SEL_HI_MSB:`PF_SEL_HI_LSB];
            schmitt_d   = i_wdata[`PF_SCHMITT_MSB:`PF_SCHMITT_LSB];
        end
        if (wr_alt) begin
            alt_d = i_wdata & (`ALT_RW_MASK | `ALT_PB15_MASK);
        end
    end

    // Register state
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            pf_sel_hi_q <= `PF_SEL_PS2_RST;
            schmitt_q   <= `PF_SCHMITT_RST;
            alt_q       <= `ALT_RESET;
        end else begin
            pf_sel_hi_q <= pf_sel_hi_d;
            schmitt_q   <= schmitt_d;
            alt_q       <= alt_d;
        end
    end

    // Read port with address decode; unmapped reads zero
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd && (i_addr == `OFS_PORT_F_FUNC)) begin
            o_rdata <= port_f_rd;
        end else if (i_rd && (i_addr == `OFS_ALT_FUNC)) begin
            o_rdata <= alt_q;
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    pin_decode_pb2 u_pb2 (
        .i_cmp_sel  (alt_q[`ALT_PB2_CMP_BIT]),
        .i_tmr_sel  (alt_q[`ALT_PB2_TMR_BIT]),
        .i_port_sel (i_port_b_sel[2]),
        .o_func     (pb2_fn)
    );

    pin_decode_two #(
        .FN_PORT_ONLY (`FN_PB8_TMR0_OUT),
        .FN_BOTH      (`FN_PB8_CLK_OUT)
    ) u_pb8 (
        .i_alt_sel  (alt_q[`ALT_PB8_CLK_BIT]),
        .i_port_sel (i_port_b_sel[8]),
        .o_func     (pb8_fn)
    );

    pin_decode_two #(
        .FN_PORT_ONLY (`FN_PB15_EXT_EXTERNAL_INTERRUPT_1),
        .FN_BOTH      (`FN_PB15_TMR0_EXT)
    ) u_pb15 (
        .i_alt_sel  (alt_q[`ALT_PB15_BIT]),
        .i_port_sel (i_port_b_sel[15]),
        .o_func     (pb15_fn)
    );

    // Registered pin routing outputs
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_pf3_ps2_port_clock_line   <= 1'b1;
            o_pf2_ps2_port_data_line   <= 1'b1;
            o_pf1_xtal_in   <= xtal_cfg;         // Crystal pins keep config in reset
            o_pf0_xtal_out  <= xtal_cfg;
            o_pf_schmitt_en <= `PF_SCHMITT_RST;
            o_pb2_func      <= `FN_GPIO;
            o_pb8_func      <= `FN_GPIO;
            o_pb15_func     <= `FN_GPIO;
        end else begin
            o_pf3_ps2_port_clock_line   <= pf_sel_hi_q[1];
            o_pf2_ps2_port_data_line   <= pf_sel_hi_q[0];
            o_pf1_xtal_in   <= xtal_cfg;
            o_pf0_xtal_out  <= xtal_cfg;
            o_pf_schmitt_en <= schmitt_q;
            o_pb2_func      <= pb2_fn;
            o_pb8_func      <= pb8_fn;
            o_pb15_func     <= pb15_fn;
        end
    end

endmodule
`default_nettype wire

/* File: verification/pin_side_model.sv */
// Package-pin side model: configuration word and port B selects
`timescale 1ns/1ps
`default_nettype none
module pin_side_model (
    input  wire logic        i_xtal_cfg,    // Crystal pin option
    input  wire logic        i_pb_sel,      // Select for PB.2, PB.8, PB.15
    output logic      [31:0] o_config_word, // Configuration word
    output logic      [15:0] o_port_b_sel   // Port B selects
);
    // Neighbour bits set so a wrong bit pick shows
    assign o_config_word = {4'ha, i_xtal_cfg, 27'h5a5_a5a5};
    assign o_port_b_sel  = {i_pb_sel, 6'h2a, i_pb_sel, 5'h0a, i_pb_sel, 2'h1};
endmodule
`default_nettype wire

/* File: verification/pin_func_select_assertions.sv */
// Port assertions for the pin function block
`timescale 1ns/1ps
`default_nettype none
`include "pin_func_map.vh"
module pin_func_checker (
    input wire logic        i_clk_sys,       // Clock
    input wire logic        i_rst,           // Reset
    input wire logic [7:0]  i_addr,          // Address
    input wire logic        i_rd,            // Read strobe
    input wire logic [31:0] o_rdata,         // Read data
    input wire logic [31:0] i_config_word,   // Config word
    input wire logic [15:0] i_port_b_sel,    // Port B selects
    input wire logic        o_pf3_ps2_port_clock_line,   // PF.3
    input wire logic        o_pf2_ps2_port_data_line,   // PF.2
    input wire logic        o_pf1_xtal_in,   // PF.1
    input wire logic        o_pf0_xtal_out,  // PF.0
    input wire logic [3:0]  o_pf_schmitt_en, // Schmitt enables
    input wire logic [2:0]  o_pb2_func,      // PB.2 code
    input wire logic [2:0]  o_pb8_func,      // PB.8 code
    input wire logic [2:0]  o_pb15_func      // PB.15 code
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    property p_rst; $past(i_rst) |-> {o_pf3_ps2_port_clock_line, o_pf2_ps2_port_data_line, o_pf_schmitt_en,
        o_pb2_func, o_pb8_func, o_pb15_func} == 15'h6000; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_xtal; !$past(i_rst) |-> {o_pf1_xtal_in, o_pf0_xtal_out}
        == {2{$past(i_config_word[27])}}; endproperty
    a_xtal: assert property (p_xtal) else $error("crystal select wrong");
    property p_idle; !$past(i_rd) |-> o_rdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    property p_rdf; $past(i_rd && i_addr == 8'h44) |-> o_rdata[31:20] == 12'h0
        && o_rdata[15:4] == 12'h0 && o_rdata[1:0] == {2{$past(i_config_word[27])}}; endproperty
    a_rdf: assert property (p_rdf) else $error("port f read wrong");
    property p_rda; $past(i_rd && i_addr == 8'h50) |-> (o_rdata & 32'h9aff_ffff) == 32'h0;
    endproperty
    a_rda: assert property (p_rda) else $error("alt reserved bit set");
    property p_rdu; $past(i_rd && i_addr != 8'h44 && i_addr != 8'h50) |-> o_rdata == 32'h0;
    endproperty
    a_rdu: assert property (p_rdu) else $error("unmapped read not zero");
    property p_pb2; !$past(i_rst) && !$past(i_port_b_sel[2]) |-> o_pb2_func == 3'h0; endproperty
    a_pb2: assert property (p_pb2) else $error("pb2 not gpio");
    property p_pb8; !$past(i_rst) && !$past(i_port_b_sel[8]) |-> o_pb8_func == 3'h0; endproperty
    a_pb8: assert property (p_pb8) else $error("pb8 not gpio");
    property p_pb15; !$past(i_rst) && !$past(i_port_b_sel[15]) |-> o_pb15_func == 3'h0;
    endproperty
    a_pb15: assert property (p_pb15) else $error("pb15 not gpio");
endmodule
bind pin_func_select pin_func_checker u_chk (
    .i_clk_sys       (i_clk_sys),
    .i_rst           (i_rst),
    .i_addr          (i_addr),
    .i_rd            (i_rd),
    .o_rdata         (o_rdata),
    .i_config_word   (i_config_word),
    .i_port_b_sel    (i_port_b_sel),
    .o_pf3_ps2_port_clock_line   (o_pf3_ps2_port_clock_line),
    .o_pf2_ps2_port_data_line   (o_pf2_ps2_port_data_line),
    .o_pf1_xtal_in   (o_pf1_xtal_in),
    .o_pf0_xtal_out  (o_pf0_xtal_out),
    .o_pf_schmitt_en (o_pf_schmitt_en),
    .o_pb2_func      (o_pb2_func),
    .o_pb8_func      (o_pb8_func),
    .o_pb15_func     (o_pb15_func)
);
`default_nettype wire

/* File: verification/tb.sv */
// Register-level testbench for the pin function block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
    logic        clk = 0, rst = 1, wr = 0, rd = 0, cfg = 1, pbs = 0, p3, p2, p1, p0;
    logic [7:0]  addr = 0;
    logic [31:0] wdata = 0, rdata, cw;
    logic [15:0] pb;
    logic [3:0]  st;
    logic [2:0]  f2, f8, f15;
    logic [2:0]  t2[8] = '{3'h0, 3'h1, 3'h0, 3'h2, 3'h0, 3'h3, 3'h0, 3'h0};
    int          fail_count = 0, check_count = 0;
    pin_side_model pm (.i_xtal_cfg(cfg), .i_pb_sel(pbs), .o_config_word(cw), .o_port_b_sel(pb));
    pin_func_select dut (.i_clk_sys(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_config_word(cw), .i_port_b_sel(pb),
        .o_pf3_ps2_port_clock_line(p3), .o_pf2_ps2_port_data_line(p2), .o_pf1_xtal_in(p1), .o_pf0_xtal_out(p0),
        .o_pf_schmitt_en(st), .o_pb2_func(f2), .o_pb8_func(f8), .o_pb15_func(f15));
    initial forever #2.5 clk = ~clk;
    // Bus write, read-and-compare, and output settling
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK("rdata", e, rdata)
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        #5000;
        fail_count++;
        complete_run();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        `CHK("pins", 4'hf, {p3, p2, p1, p0})
        `CHK("idle", 13'h0, {st, f2, f8, f15})
        rd_chk(8'h44, 32'h0000_000f);
        rd_chk(8'h50, 32'h0);
        $display("reset test done");
        wr_reg(8'h44, 32'hffff_fff0);
        rd_chk(8'h44, 32'h000f_0003);
        cfg <= 1'b0;
        settle();
        `CHK("pf", 8'h0f, {p3, p2, p1, p0, st})
        rd_chk(8'h44, 32'h000f_0000);
        wr_reg(8'h44, 32'h0005_000f);
        settle();
        `CHK("pf", 8'hc5, {p3, p2, p1, p0, st})
        $display("port f test done");
        wr_reg(8'h48, 32'hffff_ffff);
        rd_chk(8'h48, 32'h0);
        rd_chk(8'h44, 32'h0005_000c);
        wr_reg(8'h50, 32'hffff_ffff);
        rd_chk(8'h50, 32'h6500_0000);
        $display("access test done");
        for (int i = 0; i < 8; i++) begin
            wr_reg(8'h50, {1'b0, i[2], i[1], 2'b0, i[1], 1'b0, i[2], 24'h0});
            pbs <= i[0];
            settle();
            `CHK("pb2", t2[i], f2)
            `CHK("pb8", i[0] ? (i[1] ? 3'h2 : 3'h1) : 3'h0, f8)
            `CHK("pb15", i[0] ? (i[2] ? 3'h2 : 3'h1) : 3'h0, f15)
        end
        $display("decode test done");
        complete_run();
    end
endmodule
`default_nettype wire
